// file: include/dcc_pkg.sv
// shared constants and types for the dma channel with crc checker
package dcc_pkg;

	// ----------------------------------------
	// data path
	// ----------------------------------------
	localparam int          AW         = 32;           // address width
	localparam int          DW         = 32;           // data path width
	localparam int          CW         = 16;           // element counter width
	localparam int          FIFO_DEPTH = 8;            // words between channels
	localparam int          WORD_SHIFT = 2;            // byte offset of a word index
	localparam logic [31:0] WORD_BYTES = 32'h4;        // step to the next word
	localparam logic [31:0] CRC_SEED   = 32'hffffffff; // signature start value

	// ----------------------------------------
	// descriptor formats and layout
	// ----------------------------------------
	localparam logic [1:0] FMT_RING   = 2'h0; // 1d ping-pong ring, two words
	localparam logic [1:0] FMT_LIST   = 2'h1; // 1d linked list, four words
	localparam logic [1:0] FMT_ARRAY  = 2'h2; // 2d array, one word
	localparam logic [1:0] FMT_LIST2D = 2'h3; // 2d linked list, seven words
	localparam logic [2:0] LAST_RING   = 3'h1; // last word index per format
	localparam logic [2:0] LAST_LIST   = 3'h3;
	localparam logic [2:0] LAST_ARRAY  = 3'h0;
	localparam logic [2:0] LAST_LIST2D = 3'h6;
	localparam int         CFG_STOP   = 0;    // config word: end of chain
	localparam int         CFG_CIRC   = 1;    // config word: repeat sequence

	// descriptor word meaning
	typedef enum logic [2:0] {
		F_NEXT  = 3'h0,
		F_ADDR  = 3'h1,
		F_XCNT  = 3'h2,
		F_XSTEP = 3'h3,
		F_YCNT  = 3'h4,
		F_YSTEP = 3'h5,
		F_CFG   = 3'h6
	} dcc_field_t;

	// ----------------------------------------
	// checking unit modes
	// ----------------------------------------
	localparam logic [1:0] CRC_SCAN   = 2'h0; // signature only
	localparam logic [1:0] CRC_XFER   = 2'h1; // signature and copy
	localparam logic [1:0] CRC_VERIFY = 2'h2; // compare words to a constant
	localparam logic [1:0] CRC_FILL   = 2'h3; // write a constant

	// channel sequencer states
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_FETCH = 5'h02,
		ST_ARM   = 5'h04,
		ST_RUN   = 5'h08,
		ST_DRAIN = 5'h10
	} dcc_state_t;

endpackage

// file: hdl/dcc_dma_channel.sv
// memory-to-memory dma channel pair with crc32 checking unit
//
// Notes on behaviour
// RULE1 - stream uses a source and destination channel
// RULE2 - software starts register mode by writing setup
// RULE3 - completion reloads working state from setup
// RULE4 - descriptor mode fetches parameters, follows links
// RULE5 - linear buffer stops when fully moved
// RULE6 - element step may be negative, positive, zero
// RULE7 - circular buffer wraps, interrupts when full
// RULE8 - optional interrupt at half buffer (2d buffers pulse at half of the last row instead)
// RULE9 - ring of two-word descriptors: link, address
// RULE10 - four-word descriptors: link, address, length, config
// RULE11 - one-word array descriptors change address only
// RULE12 - 2d linked descriptors load every parameter
// RULE13 - system clock, 32-bit data path
// RULE14 - crc32 signature over 32-bit words
// RULE15 - scan reads source; transfer forwards to destination
// RULE16 - signature mismatch against expected raises fault
// RULE17 - verify mode and 1d/2d fill mode
// RULE18 - programmable polynomial, bit and byte mirroring
// RULE19 - separate fault and error outputs
// RULE20 - mismatch flag held until software clears
`timescale 1ns/1ns

// ----------------------------------------
// word fifo between source and destination
// ----------------------------------------
module dcc_fifo #(
	parameter int W = 32,
	parameter int D = 8
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int PW = $clog2(D);

	logic [W-1:0] mem_q [D];  // storage
	logic [PW-1:0] wp_q;      // write pointer
	logic [PW-1:0] rp_q;      // read pointer
	logic [PW:0]   cnt_q;     // words held

	assign in_ready  = (cnt_q != (PW+1)'(D));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rp_q];

	// pointers and count
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (in_valid && in_ready) begin
				wp_q <= (wp_q == PW'(D-1)) ? '0 : wp_q + 1'b1;
			end
			if (out_valid && out_ready) begin
				rp_q <= (rp_q == PW'(D-1)) ? '0 : rp_q + 1'b1;
			end
			cnt_q <= cnt_q + (PW+1)'(in_valid && in_ready) - (PW+1)'(out_valid && out_ready);
		end
	end

	// storage write
	always_ff @(posedge clk) begin
		if (in_valid && in_ready) begin
			mem_q[wp_q] <= in_data;
		end
	end
endmodule

// ----------------------------------------
// channel pair and checking unit
// ----------------------------------------
module dcc_dma_channel (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// channel control
	input  wire logic        start,
	input  wire logic        stop_req,
	input  wire logic        desc_mode,
	input  wire logic [1:0]  desc_fmt,
	input  wire logic [31:0] desc_ptr,
	input  wire logic [15:0] desc_num,
	input  wire logic        circ_en,
	input  wire logic        frac_en,
	// transfer setup
	input  wire logic [31:0] src_addr,
	input  wire logic [15:0] x_count,
	input  wire logic [31:0] x_step,
	input  wire logic [15:0] y_count,
	input  wire logic [31:0] y_step,
	input  wire logic [31:0] dst_addr,
	input  wire logic [31:0] dst_step,
	// checking unit setup
	input  wire logic [1:0]  crc_mode,
	input  wire logic [31:0] crc_poly,
	input  wire logic        bit_rev,
	input  wire logic        byte_rev,
	input  wire logic [31:0] crc_expect,
	input  wire logic [31:0] fill_value,
	input  wire logic        fault_clr,
	// source read port
	output logic             rd_req,
	output logic [31:0]      rd_addr,
	input  wire logic        rd_ack,
	input  wire logic [31:0] rd_data,
	// destination write port
	output logic             wr_req,
	output logic [31:0]      wr_addr,
	output logic [31:0]      wr_data,
	input  wire logic        wr_ack,
	// status
	output logic             busy,
	output logic             seq_done,
	output logic             frac_irq,
	output logic [31:0]      crc_value,
	output logic             crc_fault,
	output logic             crc_error,
	output logic             mismatch_flag
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	dcc_pkg::dcc_state_t state_q;  // sequencer
	dcc_pkg::dcc_field_t fld;      // meaning of the fetched word
	logic [31:0] ptr_q;            // current descriptor
	logic [31:0] nxt_q;            // link to next descriptor
	logic [2:0]  idx_q;            // word within descriptor
	logic [15:0] dleft_q;          // array entries left
	logic [1:0]  fmt_q;            // descriptor format
	logic        dmode_q;          // descriptor mode
	logic [31:0] base_q;           // buffer start
	logic [31:0] addr_q;           // source element address
	logic [15:0] xlen_q;           // elements per row
	logic [31:0] xstep_q;          // step between elements
	logic [15:0] ylen_q;           // rows
	logic [31:0] ystep_q;          // step between rows
	logic [15:0] xrem_q;           // elements left in row
	logic [15:0] yrem_q;           // rows left
	logic        circ_q;           // repeat sequence
	logic        cstop_q;          // end of chain
	logic        rd_req_q;         // read outstanding
	logic [31:0] rd_addr_q;        // read address
	logic        wr_req_q;         // write outstanding
	logic [31:0] wr_addr_q;        // write address
	logic [31:0] wr_data_q;        // write data
	logic [31:0] crc_q;            // running signature
	logic        done_q;           // sequence end pulse
	logic        frac_q;           // half buffer pulse
	logic        fault_q;          // signature mismatch pulse
	logic        err_q;            // operational error pulse
	logic        flag_q;           // sticky mismatch

	// fifo hookup and derived strobes
	logic        f_in_valid;
	logic        f_in_ready;
	logic        f_out_valid;
	logic [31:0] f_out_data;
	logic        fill_m;           // constant source
	logic        push_m;           // words go to destination
	logic        read_m;           // words come from memory
	logic        word_v;           // a source word is taken
	logic [31:0] word;             // that source word
	logic        seq_end;          // all words written
	logic        dst_load;         // reload destination address
	logic [2:0]  last_idx;         // last word of descriptor

	assign fill_m     = (crc_mode == dcc_pkg::CRC_FILL);
	assign push_m     = fill_m || (crc_mode == dcc_pkg::CRC_XFER); // RULE15
	assign read_m     = !fill_m;
	assign word_v     = (state_q == dcc_pkg::ST_RUN) && (fill_m ? f_in_ready : rd_ack);
	assign word       = fill_m ? fill_value : rd_data; // RULE17
	assign f_in_valid = word_v && push_m;
	assign seq_end    = (state_q == dcc_pkg::ST_DRAIN) && !f_out_valid && !wr_req_q;
	assign dst_load   = ((state_q == dcc_pkg::ST_IDLE) && start) || (seq_end && !dmode_q);

	// outputs
	assign rd_req        = rd_req_q;
	assign rd_addr       = rd_addr_q;
	assign wr_req        = wr_req_q;
	assign wr_addr       = wr_addr_q;
	assign wr_data       = wr_data_q;
	assign busy          = (state_q != dcc_pkg::ST_IDLE);
	assign seq_done      = done_q;
	assign frac_irq      = frac_q;
	assign crc_value     = crc_q;
	assign crc_fault     = fault_q;
	assign crc_error     = err_q;
	assign mismatch_flag = flag_q;

	// ----------------------------------------
	// descriptor word decode
	// ----------------------------------------
	always_comb begin
		fld      = dcc_pkg::F_ADDR;
		last_idx = dcc_pkg::LAST_ARRAY;
		case (fmt_q)
			dcc_pkg::FMT_RING: begin // RULE9
				last_idx = dcc_pkg::LAST_RING;
				fld      = (idx_q == 3'h0) ? dcc_pkg::F_NEXT : dcc_pkg::F_ADDR;
			end
			dcc_pkg::FMT_LIST: begin // RULE10
				last_idx = dcc_pkg::LAST_LIST;
				case (idx_q)
					3'h0:    fld = dcc_pkg::F_NEXT;
					3'h1:    fld = dcc_pkg::F_ADDR;
					3'h2:    fld = dcc_pkg::F_XCNT;
					default: fld = dcc_pkg::F_CFG;
				endcase
			end
			dcc_pkg::FMT_LIST2D: begin // RULE12
				last_idx = dcc_pkg::LAST_LIST2D;
				fld      = dcc_pkg::dcc_field_t'(idx_q);
			end
			default: begin // RULE11
				last_idx = dcc_pkg::LAST_ARRAY;
				fld      = dcc_pkg::F_ADDR;
			end
		endcase
	end

	// ----------------------------------------
	// source channel sequencer
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_q   <= dcc_pkg::ST_IDLE;
			ptr_q     <= '0;
			nxt_q     <= '0;
			idx_q     <= '0;
			dleft_q   <= '0;
			fmt_q     <= '0;
			dmode_q   <= 1'b0;
			base_q    <= '0;
			addr_q    <= '0;
			xlen_q    <= '0;
			xstep_q   <= '0;
			ylen_q    <= '0;
			ystep_q   <= '0;
			xrem_q    <= '0;
			yrem_q    <= '0;
			circ_q    <= 1'b0;
			cstop_q   <= 1'b0;
			rd_req_q  <= 1'b0;
			rd_addr_q <= '0;
			done_q    <= 1'b0;
			frac_q    <= 1'b0;
		end else begin
			done_q <= 1'b0;
			frac_q <= 1'b0;
			case (state_q)
				dcc_pkg::ST_IDLE: begin
					if (start) begin // RULE2
						base_q  <= src_addr;
						xlen_q  <= x_count;
						xstep_q <= x_step;
						ylen_q  <= y_count;
						ystep_q <= y_step;
						circ_q  <= circ_en;
						cstop_q <= 1'b0;
						dmode_q <= desc_mode;
						fmt_q   <= desc_fmt;
						ptr_q   <= desc_ptr;
						dleft_q <= desc_num;
						idx_q   <= '0;
						state_q <= desc_mode ? dcc_pkg::ST_FETCH : dcc_pkg::ST_ARM; // RULE4
					end
				end
				dcc_pkg::ST_FETCH: begin
					// one descriptor word per read
					if (!rd_req_q) begin
						rd_req_q  <= 1'b1;
						rd_addr_q <= ptr_q + ({29'h0, idx_q} << dcc_pkg::WORD_SHIFT);
					end else if (rd_ack) begin
						rd_req_q <= 1'b0;
						case (fld)
							dcc_pkg::F_NEXT:  nxt_q   <= rd_data;
							dcc_pkg::F_ADDR:  base_q  <= rd_data;
							dcc_pkg::F_XCNT:  xlen_q  <= rd_data[dcc_pkg::CW-1:0];
							dcc_pkg::F_XSTEP: xstep_q <= rd_data;
							dcc_pkg::F_YCNT:  ylen_q  <= rd_data[dcc_pkg::CW-1:0];
							dcc_pkg::F_YSTEP: ystep_q <= rd_data;
							default: begin
								cstop_q <= rd_data[dcc_pkg::CFG_STOP];
								circ_q  <= rd_data[dcc_pkg::CFG_CIRC];
							end
						endcase
						idx_q <= idx_q + 3'h1;
						if (idx_q == last_idx) begin
							// array entries sit back to back
							ptr_q   <= (fmt_q == dcc_pkg::FMT_ARRAY) ? ptr_q + dcc_pkg::WORD_BYTES
							                                          : nxt_q;
							if (fld == dcc_pkg::F_NEXT) begin
								ptr_q <= rd_data;
							end
							state_q <= dcc_pkg::ST_ARM;
						end
					end
				end
				dcc_pkg::ST_ARM: begin
					// restart at buffer start
					addr_q  <= base_q; // RULE7
					xrem_q  <= xlen_q;
					yrem_q  <= ylen_q;
					state_q <= (xlen_q == '0) ? dcc_pkg::ST_IDLE : dcc_pkg::ST_RUN;
				end
				dcc_pkg::ST_RUN: begin
					// issue next read only with room for its word
					if (!rd_req_q && read_m && (f_in_ready || !push_m)) begin
						rd_req_q  <= 1'b1;
						rd_addr_q <= addr_q;
					end else if (rd_ack) begin
						rd_req_q <= 1'b0;
					end
					if (word_v) begin
						if (xrem_q == 16'h1) begin
							if (yrem_q <= 16'h1) begin
								state_q <= dcc_pkg::ST_DRAIN; // RULE5
							end else begin
								yrem_q <= yrem_q - 16'h1;
								xrem_q <= xlen_q;
								addr_q <= addr_q + ystep_q; // RULE17
							end
						end else begin
							xrem_q <= xrem_q - 16'h1;
							addr_q <= addr_q + xstep_q; // RULE6
						end
						if (frac_en && (yrem_q <= 16'h1) && (xrem_q == (xlen_q >> 1) + 16'h1)) begin
							frac_q <= 1'b1; // RULE8
						end
					end
				end
				dcc_pkg::ST_DRAIN: begin
					// wait until the destination has written every word
					if (seq_end) begin
						done_q <= 1'b1; // RULE7
						idx_q  <= '0;
						if (stop_req) begin
							state_q <= dcc_pkg::ST_IDLE;
						end else if (dmode_q) begin
							if (circ_q) begin
								state_q <= dcc_pkg::ST_ARM;
							end else if (fmt_q == dcc_pkg::FMT_ARRAY) begin
								dleft_q <= dleft_q - 16'h1;
								state_q <= (dleft_q <= 16'h1) ? dcc_pkg::ST_IDLE
								                              : dcc_pkg::ST_FETCH;
							end else begin
								state_q <= cstop_q ? dcc_pkg::ST_IDLE : dcc_pkg::ST_FETCH; // RULE4
							end
						end else begin
							// reload working setup
							base_q  <= src_addr; // RULE3
							xlen_q  <= x_count;
							xstep_q <= x_step;
							ylen_q  <= y_count;
							ystep_q <= y_step;
							state_q <= circ_q ? dcc_pkg::ST_ARM : dcc_pkg::ST_IDLE;
						end
					end
				end
				default: state_q <= dcc_pkg::ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// word fifo
	// ----------------------------------------
	dcc_fifo #(
		.W (dcc_pkg::DW), // RULE13
		.D (dcc_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.nrst      (nrst),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   (word),
		.out_valid (f_out_valid),
		.out_ready (!wr_req_q),
		.out_data  (f_out_data)
	);

	// ----------------------------------------
	// destination channel
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wr_req_q  <= 1'b0;
			wr_addr_q <= '0;
			wr_data_q <= '0;
		end else begin
			if (dst_load) begin
				wr_addr_q <= dst_addr; // RULE3
			end else if (wr_req_q && wr_ack) begin
				wr_req_q  <= 1'b0;
				wr_addr_q <= wr_addr_q + dst_step;
			end else if (!wr_req_q && f_out_valid) begin
				wr_req_q  <= 1'b1; // RULE1
				wr_data_q <= f_out_data;
			end
		end
	end

	// ----------------------------------------
	// crc32 engine
	// ----------------------------------------
	function automatic logic [31:0] mirror(input logic [31:0] d);
		logic [31:0] b;
		logic [31:0] r;
		b = byte_rev ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
		r = b;
		if (bit_rev) begin
			for (int i = 0; i < 32; i++) begin
				r[i] = b[31-i];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
		logic [31:0] r;
		logic        fb;
		r = c;
		for (int i = 31; i >= 0; i--) begin
			fb = r[31] ^ d[i];
			r  = {r[30:0], 1'b0} ^ (fb ? crc_poly : 32'h0);
		end
		return r;
	endfunction

	// signature over each source word
	always_ff @(posedge clk) begin
		if (!nrst) begin
			crc_q <= dcc_pkg::CRC_SEED;
		end else if (state_q == dcc_pkg::ST_ARM) begin
			crc_q <= dcc_pkg::CRC_SEED;
		end else if (word_v) begin
			crc_q <= crc_step(crc_q, mirror(word)); // RULE14 RULE18
		end
	end

	// ----------------------------------------
	// fault and error reporting
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			fault_q <= 1'b0;
			err_q   <= 1'b0;
			flag_q  <= 1'b0;
		end else begin
			fault_q <= seq_end && !push_m && (crc_mode == dcc_pkg::CRC_SCAN) && (crc_q != crc_expect)
			        || seq_end && (crc_mode == dcc_pkg::CRC_XFER) && (crc_q != crc_expect); // RULE16
			err_q   <= (word_v && (crc_mode == dcc_pkg::CRC_VERIFY) && (word != fill_value))
			        || ((state_q == dcc_pkg::ST_ARM) && (xlen_q == '0)); // RULE19
			// set wins over clear
			if (fault_q || err_q) begin
				flag_q <= 1'b1; // RULE20
			end else if (fault_clr) begin
				flag_q <= 1'b0;
			end
		end
	end
endmodule

// file: tb/dcc_chk.sv
// port checker for the dma channel pair
`timescale 1ns/1ns

module dcc_chk (
	// clock and reset
	input wire logic	clk,
	input wire logic	nrst,
	// control
	input wire logic	start,
	input wire logic	fault_clr,
	input wire logic [1:0]	crc_mode,
	input wire logic [31:0]	dst_step,
	input wire logic [31:0]	crc_expect,
	// memory ports
	input wire logic	rd_req,
	input wire logic [31:0]	rd_addr,
	input wire logic	rd_ack,
	input wire logic	wr_req,
	input wire logic [31:0]	wr_addr,
	input wire logic [31:0]	wr_data,
	input wire logic	wr_ack,
	// status
	input wire logic	busy,
	input wire logic	seq_done,
	input wire logic	frac_irq,
	input wire logic [31:0]	crc_value,
	input wire logic	crc_fault,
	input wire logic	crc_error,
	input wire logic	mismatch_flag
);
	// ----------------------------------------
	// one clock domain
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_rd_hold: assert property (rd_req && !rd_ack |=> rd_req && $stable(rd_addr))
		else $error("read request not held");
	a_wr_hold: assert property (wr_req && !wr_ack |=> wr_req && $stable(wr_addr) && $stable(wr_data))
		else $error("write request not held");
	a_rd_release: assert property (rd_req && rd_ack |=> !rd_req && $stable(rd_addr))
		else $error("read not released");
	a_wr_advance: assert property (wr_req && wr_ack |=> !wr_req && wr_addr == $past(wr_addr) + dst_step)
		else $error("write address not stepped");
	a_flag_hold: assert property (mismatch_flag && !fault_clr |=> mismatch_flag)
		else $error("mismatch flag lost");
	a_flag_set: assert property (crc_fault || crc_error |=> mismatch_flag)
		else $error("mismatch flag not set");
	a_flag_clear: assert property (fault_clr && !crc_fault && !crc_error |=> !mismatch_flag)
		else $error("mismatch flag not cleared");
	a_fault_cause: assert property (crc_fault |-> crc_value != crc_expect)
		else $error("fault without mismatch");
	a_done_pulse: assert property (seq_done |=> !seq_done)
		else $error("done longer than a cycle");
	a_frac_pulse: assert property (frac_irq |=> !frac_irq)
		else $error("half pulse too long");
	a_fill_noread: assert property (busy && crc_mode == dcc_pkg::CRC_FILL |-> !rd_req)
		else $error("read during fill");
	a_scan_nowrite: assert property (busy && crc_mode[1] == crc_mode[0] |-> crc_mode[1] || !wr_req)
		else $error("write during scan");
	a_start_busy: assert property (start && !busy |=> busy)
		else $error("start not taken");

	// main scenarios
	c_done: cover property (seq_done);
	c_frac: cover property (frac_irq);
	c_fault: cover property (crc_fault);
	c_error: cover property (crc_error);
endmodule

bind dcc_dma_channel dcc_chk u_chk (.*);

// file: tb/dcc_mem_model.sv
// memory completer seen by the read and write ports
`timescale 1ns/1ns

module dcc_mem_model (
	// clock and reset
	input wire logic	clk,
	input wire logic	nrst,
	// pacing: high adds wait cycles
	input wire logic	slow,
	// read side
	input wire logic	rd_req,
	input wire logic [31:0]	rd_addr,
	output logic	rd_ack,
	output logic [31:0]	rd_data,
	// write side
	input wire logic	wr_req,
	input wire logic [31:0]	wr_addr,
	input wire logic [31:0]	wr_data,
	output logic	wr_ack
);
	logic [31:0]	mem [256];	// word store
	logic [1:0]	rcnt_q;	// read wait count
	logic [1:0]	wcnt_q;	// write wait count

	// preload a known pattern
	initial begin
		for (int k = 0; k < 256; k++) mem[k] = {k[7:0], 8'h5a, ~k[7:0], 8'hc3};
	end

	// read answer; idle data toggles so stale words never look valid
	always @(posedge clk) begin
		if (!nrst) begin
			rd_ack <= 1'b0;
			rcnt_q <= 2'h0;
			rd_data <= 32'h0;
		end else if (rd_ack || !rd_req) begin
			rd_ack <= 1'b0;
			rcnt_q <= 2'h0;
			rd_data <= ~rd_data;
		end else if (rcnt_q >= {slow, slow}) begin
			rd_ack <= 1'b1;
			rd_data <= mem[rd_addr[9:2]];
		end else rcnt_q <= rcnt_q + 2'h1;
	end

	// write answer, store on ack
	always @(posedge clk) begin
		if (!nrst) begin
			wr_ack <= 1'b0;
			wcnt_q <= 2'h0;
		end else if (wr_ack || !wr_req) begin
			wr_ack <= 1'b0;
			wcnt_q <= 2'h0;
		end else if (wcnt_q >= {slow, slow}) begin
			wr_ack <= 1'b1;
			mem[wr_addr[9:2]] <= wr_data;
		end else wcnt_q <= wcnt_q + 2'h1;
	end
endmodule

// file: tb/tb_top.sv
// self-checking bench for the dma channel pair
`timescale 1ns/1ns

module tb_top;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic	clk = 0, nrst = 0, start = 0, stop_req = 0, circ_en = 0, frac_en = 0;
	logic	fault_clr = 0, byte_rev = 0, slow = 0, desc_mode = 0, bit_rev = 0;
	logic [1:0]	crc_mode = 0, desc_fmt = 0;
	logic [15:0]	x_count = 0, y_count = 0, desc_num = 0;
	logic [31:0]	src_addr = 0, x_step = 0, y_step = 0, dst_addr = 32'h200, dst_step = 32'h4;
	logic [31:0]	crc_poly = 32'h04c11db7, crc_expect = 0, fill_value = 0, desc_ptr = 0;
	logic	rd_req, rd_ack, wr_req, wr_ack, busy, seq_done, frac_irq;
	logic	crc_fault, crc_error, mismatch_flag;
	logic [31:0]	rd_addr, rd_data, wr_addr, wr_data, crc_value;
	int	fails = 0, samples_checked = 0;
	int	n_done = 0, n_frac = 0, n_flt = 0, n_err = 0, n_wr = 0;
	int	ne, d0, e0, f0, w0, k;
	logic [31:0]	a, c, ev [8];

	// one table row: mode, length, source, step, rows, row step, byte and bit mirror
	typedef struct {
		logic [1:0] m; logic [15:0] xc; logic [31:0] sa, xs;
		logic [15:0] yc; logic [31:0] ys; logic br;
	} dcc_row_t;
	dcc_row_t	r;
	dcc_row_t	rows [5] = '{
		'{dcc_pkg::CRC_XFER, 16'h4, 32'h40, 32'h4, 16'h0, 32'h0, 1'b0},
		'{dcc_pkg::CRC_XFER, 16'h3, 32'h50, 32'h0, 16'h0, 32'h0, 1'b0},
		'{dcc_pkg::CRC_XFER, 16'h4, 32'hc0, 32'hfffffffc, 16'h0, 32'h0, 1'b0},
		'{dcc_pkg::CRC_XFER, 16'h3, 32'h40, 32'h4, 16'h2, 32'h20, 1'b0},
		'{dcc_pkg::CRC_SCAN, 16'h5, 32'h60, 32'h4, 16'h0, 32'h0, 1'b1}};

	dcc_dma_channel dut (.*);
	dcc_mem_model u_mem (.*);

	always #5 clk = ~clk;

	// pulse and write counters
	always @(posedge clk) begin
		if (seq_done === 1'b1) n_done++;
		if (frac_irq === 1'b1) n_frac++;
		if (crc_fault === 1'b1) n_flt++;
		if (crc_error === 1'b1) n_err++;
		if (wr_req === 1'b1 && wr_ack === 1'b1) n_wr++;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] pat(int i);
		return {i[7:0], 8'h5a, ~i[7:0], 8'hc3};
	endfunction

	// msb-first signature step over one word, bytes then bits mirrored when br
	function automatic logic [31:0] crc_w(logic [31:0] s, w, p, logic br);
		logic [31:0] v, t;
		t = br ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
		v = t;
		if (br) for (int i = 0; i < 32; i++) v[i] = t[31-i];
		for (int i = 31; i >= 0; i--) s = {s[30:0], 1'b0} ^ ((s[31] ^ v[i]) ? p : 32'h0);
		return s;
	endfunction

	task automatic chk(input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic tick;
		@(posedge clk);
		#1;
	endtask

	task automatic guard(int n);
		if (n >= 3000) begin
			fails++;
			$display("unexpected hang at %0t", $time);
			tally_and_finish;
		end
	endtask

	// start a sequence and wait until idle
	task automatic go;
		int n;
		start = 1;
		tick;
		start = 0;
		for (n = 0; n < 3000 && busy !== 1'b0; n++) tick;
		guard(n);
		repeat (2) tick;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (20) tick;
		nrst = 1;
		chk(busy, 0);
		chk(crc_value, dcc_pkg::CRC_SEED);
		chk(mismatch_flag, 0);
		// table of plain transfers and scans
		foreach (rows[i]) begin
			r = rows[i];
			crc_mode = r.m; x_count = r.xc; src_addr = r.sa; x_step = r.xs;
			y_count = r.yc; y_step = r.ys; byte_rev = r.br; slow = i[0];
			bit_rev = r.br;
			crc_poly = i[0] ? 32'h1edc6f41 : 32'h04c11db7;
			a = r.sa; c = 32'hffffffff; ne = r.xc * (r.yc > 1 ? r.yc : 1);
			for (int j = 0; j < ne; j++) begin
				ev[j] = pat(a[9:2]);
				c = crc_w(c, ev[j], crc_poly, r.br);
				a = a + (((j + 1) % r.xc == 0) ? r.ys : r.xs);
			end
			crc_expect = c; w0 = n_wr; f0 = n_flt;
			go;
			chk(crc_value, c);
			chk(n_flt - f0, 0);
			chk(n_wr - w0, r.m == dcc_pkg::CRC_XFER ? ne : 0);
			for (int j = 0; j < ne && r.m == dcc_pkg::CRC_XFER; j++)
				chk(u_mem.mem[128 + j], ev[j]);
		end
		// wrong signature: fault, sticky flag, clear
		crc_mode = dcc_pkg::CRC_SCAN; byte_rev = 0; x_count = 4; src_addr = 32'h40;
		bit_rev = 0;
		x_step = 4; y_count = 0; crc_expect = 32'h0; f0 = n_flt;
		go;
		chk(n_flt - f0, 1);
		repeat (3) tick;
		chk(mismatch_flag, 1);
		fault_clr = 1;
		tick;
		fault_clr = 0;
		tick;
		chk(mismatch_flag, 0);
		// fill a 2d block, then verify it
		crc_mode = dcc_pkg::CRC_FILL; fill_value = 32'h6a6a1234; y_count = 2; w0 = n_wr;
		go;
		chk(n_wr - w0, 8);
		for (int j = 0; j < 8; j++) chk(u_mem.mem[128 + j], fill_value);
		crc_mode = dcc_pkg::CRC_VERIFY; src_addr = 32'h200; x_count = 8; y_count = 0;
		e0 = n_err;
		go;
		chk(n_err - e0, 0);
		fill_value = 32'h6a6a1235;
		go;
		chk(n_err > e0, 1);
		chk(mismatch_flag, 1);
		fault_clr = 1;
		tick;
		fault_clr = 0;
		// zero length refused with an error
		x_count = 0; e0 = n_err;
		go;
		chk(n_err > e0, 1);
		chk(busy, 0);
		// linked four-word descriptor, end of chain set in its config word
		u_mem.mem[64] = 32'h110;
		u_mem.mem[65] = 32'h44;
		u_mem.mem[66] = 32'h3;
		u_mem.mem[67] = 32'h1;
		crc_mode = dcc_pkg::CRC_XFER;
		desc_mode = 1;
		desc_fmt = dcc_pkg::FMT_LIST;
		desc_ptr = 32'h100;
		d0 = n_done;
		w0 = n_wr;
		go;
		desc_mode = 0;
		chk(n_done - d0, 1);
		chk(n_wr - w0, 3);
		chk(u_mem.mem[130], pat(19));
		// circular with half-buffer pulses, stop requested after two passes, taking effect at the end of the third
		crc_mode = dcc_pkg::CRC_XFER; x_count = 4; src_addr = 32'h40; x_step = 4;
		circ_en = 1; frac_en = 1; d0 = n_done; w0 = n_wr; f0 = n_frac;
		start = 1;
		tick;
		start = 0;
		for (k = 0; k < 3000 && n_done < d0 + 2; k++) tick;
		guard(k);
		stop_req = 1;
		for (k = 0; k < 3000 && busy !== 1'b0; k++) tick;
		guard(k);
		// let the final done and write pulses be counted
		repeat (2) tick;
		stop_req = 0;
		circ_en = 0;
		chk(n_done - d0 >= 2, 1);
		chk(n_frac - f0, n_done - d0);
		chk(n_wr - w0, 4 * (n_done - d0));
		for (int j = 0; j < 4; j++) chk(u_mem.mem[128 + j], pat(16 + j));
		tally_and_finish;
	end
endmodule
